// *** hw/als_pkg.sv ***
// Constants for the audio-to-light path: register map, reset values,
// filter shifts, gain table and timing figures.
// Assumes a 100 MHz core clock and converter samples at SAMPLE_HZ.
package als_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL_ONE  = 8'h2a;
    localparam logic [7:0] ADDR_CTRL_TWO  = 8'h2b;
    localparam logic [7:0] CTRL_ONE_RESET = 8'h03;
    localparam logic [7:0] CTRL_TWO_RESET = 8'h00;
    localparam logic [7:0] CTRL_TWO_MASK  = 8'h1f;

    // Control one fields
    localparam int GAIN_SEL_LSB    = 5;
    localparam int SYNC_MODE_BIT   = 4;
    localparam int AGC_EN_BIT      = 3;
    localparam int SYNC_EN_BIT     = 2;
    localparam int INPUT_SEL_LSB   = 0;
    // Control two fields
    localparam int AVG_EN_BIT      = 4;
    localparam int MODE_CTRL_LSB   = 2;
    localparam int SPEED_CTRL_LSB  = 0;

    localparam logic [1:0] INPUT_AUDIO = 2'h0;
    localparam logic [1:0] INPUT_NONE  = 2'h3;

    typedef enum logic [1:0] {
        ALS_SPEED_FASTEST = 2'h0,
        ALS_SPEED_FAST    = 2'h1,
        ALS_SPEED_MEDIUM  = 2'h2,
        ALS_SPEED_SLOW    = 2'h3
    } als_speed_t;

    // ------------------------------------------------------------
    // Timing and filter figures
    // ------------------------------------------------------------
    localparam int CLK_HZ          = 100_000_000;
    localparam int SAMPLE_HZ       = 20_000;
    localparam int DC_CORNER_HZ    = 400;
    localparam int SLOW_LIMIT_DHZ  = 38;
    localparam int DC_SHIFT        = $clog2(SAMPLE_HZ / (6 * DC_CORNER_HZ));
    localparam int SLOW_SHIFT      = $clog2((SAMPLE_HZ * 10) / (6 * SLOW_LIMIT_DHZ));
    localparam int SPEED_FAST_SH   = 4;
    localparam int SPEED_MED_SH    = 7;
    localparam int SPEED_FASTEST_SH = 2;

    // One-pole low-pass shifts: wide set up to about 1.7 kHz, narrow to about 830 Hz
    localparam int LPA_SHIFT_WIDE   = 3;
    localparam int LPB_SHIFT_WIDE   = 1;
    localparam int LPA_SHIFT_NARROW = 4;
    localparam int LPB_SHIFT_NARROW = 2;
    localparam int PEAK_DECAY_SH    = 6;

    // Automatic gain
    localparam int          AGC_WINDOW = 1024;
    localparam logic [15:0] AGC_HIGH   = 16'h7000;
    localparam logic [15:0] AGC_LOW    = 16'h2000;
    localparam logic [2:0]  GAIN_MAX   = 3'h7;

    // Gain per 3 dB step, unsigned with four fraction bits
    localparam logic [7:0] GAIN_TABLE [8] = '{8'h10, 8'h17, 8'h20, 8'h2d,
                                              8'h40, 8'h5a, 8'h80, 8'hb5};
    // Light curve on the top four bits of a level
    localparam logic [7:0] LIGHT_LUT [16] = '{8'h00, 8'h02, 8'h05, 8'h09,
                                              8'h0e, 8'h15, 8'h1d, 8'h27,
                                              8'h33, 8'h41, 8'h51, 8'h63,
                                              8'h78, 8'h8f, 8'hb4, 8'hff};
    localparam logic [7:0] PWM_LAST = 8'hff;

endpackage : als_pkg

// *** hw/als_stream_if.sv ***
// Valid/ready stream carrying packed duty words between the path
// and its buffer. Both ends run on the same clock.
interface als_stream_if #(parameter int W = 24) ();
    logic         valid;
    logic         ready;
    logic [W-1:0] data;

    modport source (output valid, output data, input ready);
    modport sink   (input valid, input data, output ready);
endinterface : als_stream_if

// *** hw/als_buffer.sv ***
// Two-entry buffer with valid and ready on both sides.
// Assumes one clock; a stall on the drain side fills it.
module als_buffer #(
    parameter int W     = 24,
    parameter int DEPTH = 2
) (
    input  wire logic    core_clk,
    input  wire logic    reset_n,
    als_stream_if.sink   fill,
    als_stream_if.source drain
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
        $error("DEPTH must be a power of two of at least two");
    end

    logic [W-1:0] mem_q [DEPTH];
    logic [AW:0]  wr_q;
    logic [AW:0]  rd_q;
    wire          full   = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
    wire          empty  = (wr_q == rd_q);
    wire          push   = fill.valid && !full;
    wire          pop    = drain.ready && !empty;

    assign fill.ready  = !full;
    assign drain.valid = !empty;
    assign drain.data  = mem_q[rd_q[AW-1:0]];

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            wr_q <= '0;
            rd_q <= '0;
        end else begin
            if (push)
                wr_q <= wr_q + 1'b1;
            if (pop)
                rd_q <= rd_q + 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (push)
            mem_q[wr_q[AW-1:0]] <= fill.data;
    end
endmodule : als_buffer

// *** hw/als_core.sv ***
// Audio-to-light path: DC removal, gain, band split, peak, curve,
// integrators and PWM for the red, green and blue drivers.
// Assumes samples from an on-chip converter on core_clk.
module als_core
    import als_pkg::*;
#(
    parameter int SAMPLE_W = 12
) (
    input  wire logic                core_clk,
    input  wire logic                reset_n,
    input  wire logic [7:0]          reg_addr,
    input  wire logic                reg_wr,
    input  wire logic [7:0]          reg_wdata,
    output logic      [7:0]          reg_rdata,
    output logic      [1:0]          adc_input_sel,
    input  wire logic                sample_valid,
    input  wire logic [SAMPLE_W-1:0] sample_data,
    output logic                     sample_ready,
    output logic                     averaging_active,
    output logic                     audio_drive_active,
    output logic                     red_pwm,
    output logic                     green_pwm,
    output logic                     blue_pwm,
    output logic      [7:0]          red_duty,
    output logic      [7:0]          green_duty,
    output logic      [7:0]          blue_duty
);
    if (SAMPLE_W < 4 || SAMPLE_W > 16) begin : g_bad_width
        $error("SAMPLE_W must lie in 4..16");
    end

    // ------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------
    logic [7:0] ctrl_one_q;
    logic [7:0] ctrl_two_q;

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_one_q <= CTRL_ONE_RESET;
            ctrl_two_q <= CTRL_TWO_RESET;
        end else if (reg_wr) begin
            if (reg_addr == ADDR_CTRL_ONE)
                ctrl_one_q <= reg_wdata;
            if (reg_addr == ADDR_CTRL_TWO)
                ctrl_two_q <= reg_wdata & CTRL_TWO_MASK;
        end
    end

    wire [2:0] gain_sel   = ctrl_one_q[GAIN_SEL_LSB +: 3];
    wire       freq_mode  = ctrl_one_q[SYNC_MODE_BIT];
    wire       agc_en     = ctrl_one_q[AGC_EN_BIT];
    wire       sync_en    = ctrl_one_q[SYNC_EN_BIT];
    wire [1:0] input_sel  = ctrl_one_q[INPUT_SEL_LSB +: 2];
    wire       avg_en     = ctrl_two_q[AVG_EN_BIT];
    wire [1:0] mode_ctrl  = ctrl_two_q[MODE_CTRL_LSB +: 2];
    wire [1:0] speed_ctrl = ctrl_two_q[SPEED_CTRL_LSB +: 2];

    wire       rd_one  = (reg_addr == ADDR_CTRL_ONE);
    wire       rd_two  = (reg_addr == ADDR_CTRL_TWO);
    assign reg_rdata = rd_one ? ctrl_one_q : (rd_two ? ctrl_two_q : 8'h00);

    assign adc_input_sel    = input_sel;
    assign averaging_active = avg_en && !sync_en;
    wire   path_on          = sync_en && (input_sel == INPUT_AUDIO);
    assign audio_drive_active = sync_en;

    // ------------------------------------------------------------
    // Stream to the duty buffer
    // ------------------------------------------------------------
    als_stream_if #(.W(24)) to_buf ();
    als_stream_if #(.W(24)) from_buf ();

    als_buffer #(.W(24), .DEPTH(2)) u_buffer (
        .core_clk (core_clk),
        .reset_n  (reset_n),
        .fill     (to_buf.sink),
        .drain    (from_buf.source)
    );

    wire s_fire  = sample_valid && path_on && to_buf.ready;
    assign sample_ready = !path_on || to_buf.ready;

    // ------------------------------------------------------------
    // DC remover and gain
    // ------------------------------------------------------------
    function automatic logic signed [15:0] sat16(input logic signed [23:0] v);
        if (v > 24'sh007fff)
            sat16 = 16'sh7fff;
        else if (v < -24'sh008000)
            sat16 = -16'sh8000;
        else
            sat16 = v[15:0];
    endfunction : sat16

    function automatic logic [15:0] mag16(input logic signed [15:0] v);
        mag16 = v[15] ? 16'(-v) : v;
    endfunction : mag16

    logic signed [15:0] dc_q;
    logic        [2:0]  gain_q;
    wire  signed [15:0] x_in   = 16'(signed'(sample_data)) <<< (16 - SAMPLE_W);
    wire  signed [15:0] hp     = sat16(24'(x_in) - 24'(dc_q));
    wire  signed [15:0] dc_d   = dc_q + (hp >>> DC_SHIFT);
    wire  signed [23:0] prod   = 24'(hp) * $signed({1'b0, GAIN_TABLE[gain_q]});
    wire  signed [15:0] gained = sat16(prod >>> 4);
    wire         [15:0] g_mag  = mag16(gained);

    // ------------------------------------------------------------
    // Automatic gain
    // ------------------------------------------------------------
    logic [$clog2(AGC_WINDOW)-1:0] agc_cnt_q;
    logic [15:0]                   agc_max_q;
    wire  agc_run  = agc_en && sync_en;
    wire  agc_end  = (agc_cnt_q == '1);
    wire  agc_down = agc_max_q >= AGC_HIGH && gain_q != 3'h0;
    wire  agc_up   = agc_max_q < AGC_LOW && gain_q != GAIN_MAX;

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            gain_q    <= 3'h0;
            agc_cnt_q <= '0;
            agc_max_q <= 16'h0000;
        end else if (!agc_run) begin
            gain_q    <= gain_sel;
            agc_cnt_q <= '0;
            agc_max_q <= 16'h0000;
        end else if (s_fire) begin
            agc_cnt_q <= agc_cnt_q + 1'b1;
            agc_max_q <= agc_end ? 16'h0000 : ((g_mag > agc_max_q) ? g_mag : agc_max_q);
            if (agc_end && agc_down)
                gain_q <= gain_q - 3'h1;
            else if (agc_end && agc_up)
                gain_q <= gain_q + 3'h1;
        end
    end

    // ------------------------------------------------------------
    // Three-band filter and peak detector
    // ------------------------------------------------------------
    logic signed [15:0] lpa_q;
    logic signed [15:0] lpb_q;
    wire  narrow  = (mode_ctrl == 2'h1);
    // Differences kept wide: a 16-bit wrap would flip a band's sign
    wire  signed [16:0] lpa_err = 17'(gained) - 17'(lpa_q);
    wire  signed [16:0] lpb_err = 17'(gained) - 17'(lpb_q);
    wire  signed [15:0] lpa_d = lpa_q + 16'(lpa_err >>> (narrow ? LPA_SHIFT_NARROW : LPA_SHIFT_WIDE));
    wire  signed [15:0] lpb_d = lpb_q + 16'(lpb_err >>> (narrow ? LPB_SHIFT_NARROW : LPB_SHIFT_WIDE));
    wire  signed [15:0] band_low  = lpa_q;
    wire  signed [15:0] band_mid  = sat16(24'(lpb_q) - 24'(lpa_q));
    wire  signed [15:0] band_high = sat16(24'(gained) - 24'(lpb_q));

    logic [15:0] ch_mag [3];
    logic [15:0] peak_q [3];
    logic [15:0] peak_d [3];
    logic [7:0]  lut_v  [3];

    always_comb begin
        ch_mag[0] = freq_mode ? mag16(band_low) : g_mag;
        ch_mag[1] = mag16(band_mid);
        ch_mag[2] = mag16(band_high);
        for (int i = 0; i < 3; i++) begin
            peak_d[i] = peak_q[i] - (peak_q[i] >> PEAK_DECAY_SH);
            if (ch_mag[i] > peak_d[i])
                peak_d[i] = ch_mag[i];
            lut_v[i] = LIGHT_LUT[peak_q[i][15:12]];
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            dc_q  <= 16'sh0000;
            lpa_q <= 16'sh0000;
            lpb_q <= 16'sh0000;
            for (int i = 0; i < 3; i++)
                peak_q[i] <= 16'h0000;
        end else if (s_fire) begin
            dc_q  <= dc_d;
            lpa_q <= lpa_d;
            lpb_q <= lpb_d;
            for (int i = 0; i < 3; i++)
                peak_q[i] <= peak_d[i];
        end
    end

    // ------------------------------------------------------------
    // Mode selector
    // ------------------------------------------------------------
    logic [7:0] tgt_r;
    logic [7:0] tgt_g;
    logic [7:0] tgt_b;

    always_comb begin
        if (freq_mode) begin
            tgt_r = lut_v[0];
            tgt_b = lut_v[1];
            tgt_g = lut_v[2];
        end else begin
            case (mode_ctrl)
                2'h1: begin
                    tgt_r = lut_v[0];
                    tgt_g = lut_v[0] >> 2;
                    tgt_b = 8'h00;
                end
                2'h2: begin
                    tgt_r = lut_v[0];
                    tgt_g = lut_v[0] >> 1;
                    tgt_b = ~lut_v[0];
                end
                default: begin
                    tgt_r = lut_v[0];
                    tgt_g = lut_v[0];
                    tgt_b = lut_v[0] >> 1;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Integrators
    // ------------------------------------------------------------
    logic [4:0] speed_sh;
    always_comb begin
        case (als_speed_t'(speed_ctrl))
            ALS_SPEED_FASTEST: speed_sh = 5'(SPEED_FASTEST_SH);
            ALS_SPEED_FAST:    speed_sh = 5'(SPEED_FAST_SH);
            ALS_SPEED_MEDIUM:  speed_sh = 5'(SPEED_MED_SH);
            ALS_SPEED_SLOW:    speed_sh = 5'(SLOW_SHIFT);
            default:           speed_sh = 5'(SPEED_FASTEST_SH);
        endcase
    end

    logic signed [17:0] integ_q [3];
    logic signed [17:0] integ_d [3];
    logic        [7:0]  tgt     [3];

    always_comb begin
        tgt[0] = tgt_r;
        tgt[1] = tgt_g;
        tgt[2] = tgt_b;
        for (int i = 0; i < 3; i++)
            integ_d[i] = integ_q[i] + (($signed({2'b00, tgt[i], 8'h00}) - integ_q[i]) >>> speed_sh);
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < 3; i++)
                integ_q[i] <= 18'sh00000;
        end else if (s_fire) begin
            for (int i = 0; i < 3; i++)
                integ_q[i] <= integ_d[i];
        end
    end

    assign to_buf.valid = s_fire;
    assign to_buf.data  = {integ_d[0][15:8], integ_d[1][15:8], integ_d[2][15:8]};

    // ------------------------------------------------------------
    // PWM generator
    // ------------------------------------------------------------
    logic [7:0] pwm_cnt_q;
    logic [7:0] duty_r_q;
    logic [7:0] duty_g_q;
    logic [7:0] duty_b_q;
    logic       pwm_r_q;
    logic       pwm_g_q;
    logic       pwm_b_q;
    wire        period_end = (pwm_cnt_q == PWM_LAST);
    assign from_buf.ready = period_end && sync_en;

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            pwm_cnt_q <= 8'h00;
            duty_r_q  <= 8'h00;
            duty_g_q  <= 8'h00;
            duty_b_q  <= 8'h00;
            pwm_r_q   <= 1'b0;
            pwm_g_q   <= 1'b0;
            pwm_b_q   <= 1'b0;
        end else begin
            pwm_cnt_q <= pwm_cnt_q + 8'h01;
            if (from_buf.ready && from_buf.valid) begin
                duty_r_q <= from_buf.data[23:16];
                duty_g_q <= from_buf.data[15:8];
                duty_b_q <= from_buf.data[7:0];
            end
            pwm_r_q <= sync_en && (pwm_cnt_q < duty_r_q);
            pwm_g_q <= sync_en && (pwm_cnt_q < duty_g_q);
            pwm_b_q <= sync_en && (pwm_cnt_q < duty_b_q);
        end
    end

    assign red_pwm     = pwm_r_q;
    assign green_pwm   = pwm_g_q;
    assign blue_pwm    = pwm_b_q;
    assign red_duty    = duty_r_q;
    assign green_duty  = duty_g_q;
    assign blue_duty   = duty_b_q;
endmodule : als_core

// *** test/als_core_monitor.sv ***
// Checker for the als_core ports: register view, gating and PWM pace.
// Assumes one clock domain; bound to every als_core below the module.
module als_core_chk
    import als_pkg::*;
(
    input wire logic       core_clk,
    input wire logic       reset_n,
    input wire logic [7:0] reg_addr,
    input wire logic       reg_wr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic [1:0] adc_input_sel,
    input wire logic       sample_ready,
    input wire logic       averaging_active,
    input wire logic       audio_drive_active,
    input wire logic       red_pwm,
    input wire logic       green_pwm,
    input wire logic       blue_pwm,
    input wire logic [7:0] red_duty,
    input wire logic [7:0] green_duty,
    input wire logic [7:0] blue_duty
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----
    // Cycles since the duty word last moved
    // ----
    logic [23:0] duty_q;
    logic [8:0]  hold_q;
    wire  [23:0] duty_now   = {red_duty, green_duty, blue_duty};
    wire         duty_moved = duty_now != duty_q;
    wire  [8:0]  hold_d     = duty_moved ? 9'h000 : hold_q + {8'h00, hold_q != 9'h1ff};
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            duty_q <= 24'h00_0000;
            hold_q <= 9'h000;
        end else begin
            duty_q <= duty_now;
            hold_q <= hold_d;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);

    sequence s_wr_one;
        reg_wr && reg_addr == ADDR_CTRL_ONE;
    endsequence
    sequence s_read_one;
        reg_addr == ADDR_CTRL_ONE;
    endsequence

    chk_write_lands: assert property (s_wr_one ##1 s_read_one |-> reg_rdata == $past(reg_wdata))
        else $error("Control one write not visible next cycle");
    chk_input_route: assert property (s_read_one |-> adc_input_sel == reg_rdata[1:0])
        else $error("Converter source differs from input field");
    chk_sync_flag: assert property (s_read_one |-> audio_drive_active == reg_rdata[SYNC_EN_BIT])
        else $error("Drive flag differs from enable bit");
    chk_avg_gate: assert property (reg_addr == ADDR_CTRL_TWO |->
        averaging_active == (reg_rdata[AVG_EN_BIT] && !audio_drive_active))
        else $error("Averaging flag wrong for sync state");
    chk_reserved_zero: assert property (reg_addr == ADDR_CTRL_TWO |-> reg_rdata[7:5] == 3'h0)
        else $error("Reserved control two bits not zero");
    chk_ready_off: assert property (!audio_drive_active |-> sample_ready)
        else $error("Samples held back while path is off");
    chk_pwm_quiet: assert property ((!audio_drive_active)[*2] |-> !(red_pwm || green_pwm || blue_pwm))
        else $error("Driver on while sync disabled");
    chk_duty_frozen: assert property ((!audio_drive_active)[*2] |-> $stable(duty_now))
        else $error("Duty moved while sync disabled");
    chk_duty_pace: assert property (duty_moved |-> hold_q >= 9'h0c8)
        else $error("Duty moved inside a PWM period");
    chk_zero_dark: assert property ((red_duty == 8'h00)[*2] |-> !red_pwm)
        else $error("Red driver on with zero duty");
endmodule : als_core_chk

bind als_core als_core_chk u_chk (
    .core_clk(core_clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .adc_input_sel(adc_input_sel),
    .sample_ready(sample_ready), .averaging_active(averaging_active),
    .audio_drive_active(audio_drive_active), .red_pwm(red_pwm), .green_pwm(green_pwm),
    .blue_pwm(blue_pwm), .red_duty(red_duty), .green_duty(green_duty), .blue_duty(blue_duty)
);

// *** test/als_audio_src.sv ***
// Audio source model: signed square wave, one word per handshake.
// Assumes the core_clk domain; an idle data bus shows the last word inverted.
module als_audio_src (
    input  wire logic        core_clk,
    input  wire logic        reset_n,
    input  wire logic        src_on,
    input  wire logic [11:0] amp,
    input  wire logic [7:0]  half,
    input  wire logic        sample_ready,
    output logic             sample_valid,
    output logic      [11:0] sample_data,
    output logic      [15:0] n_taken
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [11:0] word_q;
    logic [8:0]  ph_q;
    wire         load = !sample_valid || sample_ready;
    wire  [8:0]  ph_d = (ph_q + 9'h001 >= {half, 1'b0}) ? 9'h000 : ph_q + 9'h001;
    assign sample_data = sample_valid ? word_q : ~word_q;
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            sample_valid <= 1'b0;
            word_q       <= 12'h000;
            ph_q         <= 9'h000;
            n_taken      <= 16'h0000;
        end else if (load) begin
            sample_valid <= src_on;
            n_taken      <= n_taken + {15'h0000, sample_valid};
            ph_q         <= src_on ? ph_d : 9'h000;
            word_q       <= (ph_q < {1'b0, half}) ? amp : 12'h000 - amp;
        end
    end
endmodule : als_audio_src

// *** test/test_audio_light_sync.sv ***
// Testbench for als_core: register rows, tone runs, gating and reset.
// Assumes the bound checker and the als_audio_src model beside the core.
module test_audio_light_sync
    import als_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic [7:0] rdata;
        logic [2:0] flags;
    } als_row_t;
    logic        core_clk  = 1'b0;
    logic        reset_n   = 1'b0;
    logic [7:0]  reg_addr  = 8'h2a;
    logic        reg_wr    = 1'b0;
    logic [7:0]  reg_wdata = 8'h00;
    logic        src_on    = 1'b0;
    logic [11:0] amp       = 12'h000;
    logic [7:0]  half      = 8'h01;
    logic [7:0]  reg_rdata, red_duty, green_duty, blue_duty, lo_duty;
    logic [1:0]  adc_input_sel;
    logic        sample_valid, sample_ready, averaging_active, audio_drive_active;
    logic        red_pwm, green_pwm, blue_pwm;
    logic [11:0] sample_data;
    logic [15:0] n_taken, base;
    logic [23:0] held;
    int          err_total  = 0;
    int          n_compared = 0;
    int          stalls     = 0;
    // Address, write, readback, {source select, averaging}
    als_row_t    rows [9] = '{'{8'h2a, 8'h14, 8'h14, 3'h0}, '{8'h2b, 8'h10, 8'h10, 3'h0},
                              '{8'h2a, 8'h01, 8'h01, 3'h3}, '{8'h2a, 8'h02, 8'h02, 3'h5},
                              '{8'h2b, 8'hff, 8'h1f, 3'h5}, '{8'h2b, 8'he2, 8'h02, 3'h4},
                              '{8'h2b, 8'h0d, 8'h0d, 3'h4}, '{8'h2c, 8'h55, 8'h00, 3'h4},
                              '{8'h2a, 8'he3, 8'he3, 3'h6}};

    always #5 core_clk = ~core_clk;

    als_core #(.SAMPLE_W(12)) dut (
        .core_clk(core_clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .adc_input_sel(adc_input_sel),
        .sample_valid(sample_valid), .sample_data(sample_data), .sample_ready(sample_ready),
        .averaging_active(averaging_active), .audio_drive_active(audio_drive_active),
        .red_pwm(red_pwm), .green_pwm(green_pwm), .blue_pwm(blue_pwm),
        .red_duty(red_duty), .green_duty(green_duty), .blue_duty(blue_duty)
    );
    als_audio_src src (
        .core_clk(core_clk), .reset_n(reset_n), .src_on(src_on), .amp(amp), .half(half),
        .sample_ready(sample_ready), .sample_valid(sample_valid), .sample_data(sample_data),
        .n_taken(n_taken)
    );

    // ----
    // Shared tasks
    // ----
    task automatic check(input logic [23:0] got, input logic [23:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic give_verdict;
        $display("Compared %0d, mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : give_verdict

    task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        #1;
        reg_addr  = a;
        reg_wdata = d;
        reg_wr    = 1'b1;
        @(posedge core_clk);
        #1;
        reg_wr = 1'b0;
    endtask : reg_write

    task automatic wait_taken(input int n);
        int i;
        for (i = 0; i < 30000 && int'(n_taken) < n; i++) begin
            @(negedge core_clk);
            stalls += int'(sample_valid && !sample_ready);
        end
        if (int'(n_taken) < n) begin
            err_total++;
            $display("Error at %0t: taken %h expected %h", $time, n_taken, n);
            give_verdict();
        end
    endtask : wait_taken

    // Program the path, stream 64 words, then let the buffer drain
    task automatic run(input logic [7:0] c1, input logic [7:0] c2, input logic [11:0] a, input logic [7:0] h);
        reg_write(ADDR_CTRL_TWO, c2);
        reg_write(ADDR_CTRL_ONE, c1);
        amp    = a;
        half   = h;
        src_on = 1'b1;
        wait_taken(int'(n_taken) + 64);
        @(posedge core_clk);
        #1;
        src_on = 1'b0;
        repeat (800) @(posedge core_clk);
        @(negedge core_clk);
    endtask : run

    // ----
    // Sequence
    // ----
    initial begin
        repeat (8) @(posedge core_clk);
        #1;
        reset_n = 1'b1;
        @(negedge core_clk);
        check(24'({reg_rdata, adc_input_sel, audio_drive_active, sample_ready}), 24'h00_003d);
        check({red_duty, green_duty, blue_duty}, 24'h00_0000);
        @(posedge core_clk);
        #1;
        reg_addr = ADDR_CTRL_TWO;
        @(negedge core_clk);
        check(24'(reg_rdata), 24'h00_0000);
        $display("Test reset done");
        foreach (rows[i]) begin
            reg_write(rows[i].addr, rows[i].wdata);
            @(negedge core_clk);
            check(24'(reg_rdata), 24'(rows[i].rdata));
            check(24'({adc_input_sel, averaging_active}), 24'(rows[i].flags));
        end
        $display("Test rows done");
        run(8'h04, 8'h00, 12'h100, 8'h08);
        lo_duty = red_duty;
        run(8'he4, 8'h00, 12'h100, 8'h08);
        check(24'(red_duty > lo_duty), 24'h1);
        $display("Test gain done");
        run(8'hf4, 8'h00, 12'h300, 8'h10);
        lo_duty = red_duty;
        run(8'h14, 8'h04, 12'h300, 8'h01);
        check(24'(green_duty > red_duty), 24'h1);
        check(24'(lo_duty > red_duty), 24'h1);
        check(24'(stalls > 0), 24'h1);
        $display("Test bands done");
        reg_write(ADDR_CTRL_ONE, 8'h10);
        held   = {red_duty, green_duty, blue_duty};
        base   = n_taken;
        src_on = 1'b1;
        repeat (600) @(posedge core_clk);
        @(negedge core_clk);
        check({red_duty, green_duty, blue_duty}, held);
        check(24'(n_taken - base > 16'h01f4), 24'h1);
        $display("Test disable done");
        @(posedge core_clk);
        #1;
        reset_n = 1'b0;
        repeat (2) @(posedge core_clk);
        #1;
        reset_n = 1'b1;
        @(negedge core_clk);
        check(24'({reg_rdata, green_duty}), 24'h00_0300);
        src_on = 1'b0;
        $display("Test second reset done");
        give_verdict();
    end
endmodule : test_audio_light_sync
